// >>> hdl/dppm_top.sv
/*
  Digital core of a single-channel palette video converter: two palette
  copies, pixel pair capture, 2:1 output mux, half-rate clock and an
  asynchronous strobe processor port.
  Assumes the half-rate clock output is looped back to its input outside,
  pixel inputs are timed to the pixel clock, and processor strobes and the
  data bus are asynchronous to both clocks.
*/
// Notes on behaviour
// [R1] Two 256x8 palettes, 2:1 mux, one code
// [R2] Processor access: pixel pins address, pipeline transparent
// [R3] Processor write stores byte in both palettes
// [R4] Separate read strobes read either palette
// [R5] Pixels and overlay selects captured on divider fall
// [R6] Overlay select picks colour or overlay table
// [R7] Overlay index uses lower four pixel bits
// [R8] Palette outputs alternate every pixel clock
// [R9] Looped divider output toggles at half rate
// [R10] Blank captured on same divider edge
// [R11] Captured blank forces blanking for pixel pair
// [R12] Blank stays aligned with the even pixel
// [R13] Far side blanks during processor accesses
// [R14] Far side blanks one pixel cycle afterwards
// [R15] Code ones white, zeros black, blank overrides
// [R16] Access needs chip select low; capture otherwise
// [R17] Write address on first fall, data on rise
// [R18] Processor never asserts both read strobes
// [R19] Even pixel leads, odd follows next clock
// [R20] Registered code and blank flag each clock
`timescale 1ns/1ps
module dppm_top (
  input  wire logic       CLK_IN,                // System clock, 10 MHz
  input  wire logic       SYS_RST_IN,            // Synchronous reset, active high
  input  wire logic       PIX_CLK_IN,            // Pixel clock
  input  wire logic [7:0] EVEN_PIXEL_IN,         // Even pixel byte
  input  wire logic [7:0] ODD_PIXEL_IN,          // Odd pixel byte
  input  wire logic       EVEN_OVERLAY_SEL_IN,   // Even overlay select
  input  wire logic       ODD_OVERLAY_SEL_IN,    // Odd overlay select
  input  wire logic       BLANK_IN,              // Composite blank
  input  wire logic       HALF_RATE_CLK_IN,      // Looped half-rate clock
  output      logic       HALF_RATE_CLK_N_OUT,   // Inverted half-rate clock
  input  wire logic       CHIP_SEL_N_IN,         // Chip select, active low
  input  wire logic       WRITE_STROBE_N_IN,     // Write strobe, active low
  input  wire logic       READ_STROBE_A_N_IN,    // Read palette A, active low
  input  wire logic       READ_STROBE_B_N_IN,    // Read palette B, active low
  input  wire logic [7:0] DATA_IN,               // Data bus input level
  output      logic [7:0] DATA_OUT,              // Data bus drive value
  output      logic       DATA_OE_OUT,           // Data bus drive enable
  output      logic [7:0] CODE_OUT,              // Converter code
  output      logic       BLANK_OUT              // Blanking flag
);

  // ---------------- System clock domain: processor port ----------------
  logic [3:0]                        stb_raw;
  logic [3:0]                        stb_s;
  logic [17:0]                       ab_raw;
  logic [17:0]                       ab_s;
  logic [7:0]                        data_s;
  logic                              wr_act;
  logic                              rda_act;
  logic                              rdb_act;
  dppm_pkg::dppm_cpu_state_type      cpu_state;
  dppm_pkg::dppm_cpu_state_type      next_cpu_state;
  logic [7:0]                        wr_addr_a;
  logic [7:0]                        wr_addr_b;
  logic                              wr_ovl_a;
  logic                              wr_ovl_b;
  logic [7:0]                        wr_data;
  logic                              wr_pulse;
  logic [7:0]                        cpu_rd_a;
  logic [7:0]                        cpu_rd_b;

  assign stb_raw = {READ_STROBE_B_N_IN, READ_STROBE_A_N_IN, WRITE_STROBE_N_IN, CHIP_SEL_N_IN};
  assign ab_raw  = {ODD_OVERLAY_SEL_IN, EVEN_OVERLAY_SEL_IN, ODD_PIXEL_IN, EVEN_PIXEL_IN};

  // Strobes, address pins and data pins into the system domain
  dppm_sync #(.W(dppm_pkg::SYNC_W_CPU)) u_sync_stb (
    .clk_in (CLK_IN),
    .d_in   (stb_raw),
    .q_out  (stb_s)
  );

  dppm_sync #(.W(dppm_pkg::ADDR_BUS_W)) u_sync_ab (
    .clk_in (CLK_IN),
    .d_in   (ab_raw),
    .q_out  (ab_s)
  );

  dppm_sync #(.W(dppm_pkg::DATA_W)) u_sync_data (
    .clk_in (CLK_IN),
    .d_in   (DATA_IN),
    .q_out  (data_s)
  );

  // [R16] Access qualified by chip select
  assign wr_act  = ~stb_s[dppm_pkg::STB_CS] & ~stb_s[dppm_pkg::STB_WR];
  assign rda_act = ~stb_s[dppm_pkg::STB_CS] & ~stb_s[dppm_pkg::STB_RDA];
  assign rdb_act = ~stb_s[dppm_pkg::STB_CS] & ~stb_s[dppm_pkg::STB_RDB];

  // Access sequencer next state
  always_comb begin
    next_cpu_state = cpu_state;
    case (cpu_state)
      dppm_pkg::CPU_IDLE: begin
        if (wr_act) begin
          next_cpu_state = dppm_pkg::CPU_WRITE;
        end else if (rda_act) begin
          next_cpu_state = dppm_pkg::CPU_READ_A;
        end else if (rdb_act) begin
          next_cpu_state = dppm_pkg::CPU_READ_B;
        end
      end
      dppm_pkg::CPU_WRITE: begin
        if (!wr_act) begin
          next_cpu_state = dppm_pkg::CPU_IDLE;
        end
      end
      dppm_pkg::CPU_READ_A: begin
        if (!rda_act) begin
          next_cpu_state = dppm_pkg::CPU_IDLE;
        end
      end
      dppm_pkg::CPU_READ_B: begin
        if (!rdb_act) begin
          next_cpu_state = dppm_pkg::CPU_IDLE;
        end
      end
      default: begin
        next_cpu_state = dppm_pkg::CPU_IDLE;
      end
    endcase
  end

  // Access sequencer state
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      cpu_state <= dppm_pkg::CPU_IDLE;
    end else begin
      cpu_state <= next_cpu_state;
    end
  end

  // [R17] Address caught at access start
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      wr_addr_a <= dppm_pkg::RST_BYTE;
      wr_addr_b <= dppm_pkg::RST_BYTE;
      wr_ovl_a  <= dppm_pkg::RST_BIT;
      wr_ovl_b  <= dppm_pkg::RST_BIT;
    end else if (cpu_state == dppm_pkg::CPU_IDLE && wr_act) begin
      wr_addr_a <= ab_s[dppm_pkg::AB_EVEN_HI:dppm_pkg::AB_EVEN_LO];
      wr_addr_b <= ab_s[dppm_pkg::AB_ODD_HI:dppm_pkg::AB_ODD_LO];
      wr_ovl_a  <= ab_s[dppm_pkg::AB_EVEN_OV];
      wr_ovl_b  <= ab_s[dppm_pkg::AB_ODD_OV];
    end
  end

  // [R17] Data caught at access end, with one write pulse on the same edge
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      wr_data  <= dppm_pkg::RST_BYTE;
      wr_pulse <= dppm_pkg::RST_BIT;
    end else begin
      wr_pulse <= (cpu_state == dppm_pkg::CPU_WRITE) && !wr_act;
      if (cpu_state == dppm_pkg::CPU_WRITE && !wr_act) begin
        wr_data <= data_s;
      end
    end
  end

  // [R4] Read data and bus drive per strobe
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      DATA_OUT    <= dppm_pkg::RST_BYTE;
      DATA_OE_OUT <= dppm_pkg::RST_BIT;
    end else begin
      DATA_OE_OUT <= (cpu_state == dppm_pkg::CPU_READ_A) ||
                     (cpu_state == dppm_pkg::CPU_READ_B);
      DATA_OUT    <= (cpu_state == dppm_pkg::CPU_READ_B) ? cpu_rd_b : cpu_rd_a;
    end
  end

  // ---------------- Pixel clock domain: video path ----------------
  logic       pix_rst;
  logic       cs_pix_n;
  logic       cpu_pix;
  logic       cap_ev;
  logic       load_ev;
  logic [7:0] ev_pix;
  logic [7:0] od_pix;
  logic       ev_ovl;
  logic       od_ovl;
  logic       blk_cap;
  logic       cap_d;
  logic       lead1;
  logic       blk1;
  logic       pair_blk;
  logic [7:0] pix_a_data;
  logic [7:0] pix_b_data;
  logic [7:0] odd_hold;

  // Reset and chip select into the pixel domain
  dppm_sync #(.W(1)) u_sync_rst (
    .clk_in (PIX_CLK_IN),
    .d_in   (SYS_RST_IN),
    .q_out  (pix_rst)
  );

  dppm_sync #(.W(1)) u_sync_cs (
    .clk_in (PIX_CLK_IN),
    .d_in   (CHIP_SEL_N_IN),
    .q_out  (cs_pix_n)
  );

  assign cpu_pix = ~cs_pix_n;

  // [R9] Divider output is the inverted loop input
  always_ff @(posedge PIX_CLK_IN) begin
    if (pix_rst) begin
      HALF_RATE_CLK_N_OUT <= dppm_pkg::RST_BIT;
    end else begin
      HALF_RATE_CLK_N_OUT <= ~HALF_RATE_CLK_IN;
    end
  end

  // [R5] Capture at the edge where the output falls
  assign cap_ev  = HALF_RATE_CLK_N_OUT & HALF_RATE_CLK_IN;
  // [R2] Transparent loading during processor access
  assign load_ev = cpu_pix | cap_ev;

  // [R5] [R10] Pixel pair, overlay selects and blank capture
  always_ff @(posedge PIX_CLK_IN) begin
    if (pix_rst) begin
      ev_pix  <= dppm_pkg::RST_BYTE;
      od_pix  <= dppm_pkg::RST_BYTE;
      ev_ovl  <= dppm_pkg::RST_BIT;
      od_ovl  <= dppm_pkg::RST_BIT;
      blk_cap <= dppm_pkg::RST_HIGH;
    end else if (load_ev) begin
      ev_pix  <= EVEN_PIXEL_IN;
      od_pix  <= ODD_PIXEL_IN;
      ev_ovl  <= EVEN_OVERLAY_SEL_IN;
      od_ovl  <= ODD_OVERLAY_SEL_IN;
      blk_cap <= BLANK_IN;
    end
  end

  // [R1] [R6] [R7] Both palettes; even reads A, odd reads B
  dppm_palette u_pal_a (
    .sys_clk_in   (CLK_IN),
    .wr_en_in     (wr_pulse),
    .wr_addr_in   (wr_addr_a),
    .wr_ovl_in    (wr_ovl_a),
    .wr_data_in   (wr_data),
    .cpu_addr_in  (ab_s[dppm_pkg::AB_EVEN_HI:dppm_pkg::AB_EVEN_LO]),
    .cpu_ovl_in   (ab_s[dppm_pkg::AB_EVEN_OV]),
    .cpu_data_out (cpu_rd_a),
    .pix_clk_in   (PIX_CLK_IN),
    .pix_addr_in  (ev_pix),
    .pix_ovl_in   (ev_ovl),
    .pix_data_out (pix_a_data)
  );

  // [R3] Same write pulse and byte reach the second copy
  dppm_palette u_pal_b (
    .sys_clk_in   (CLK_IN),
    .wr_en_in     (wr_pulse),
    .wr_addr_in   (wr_addr_b),
    .wr_ovl_in    (wr_ovl_b),
    .wr_data_in   (wr_data),
    .cpu_addr_in  (ab_s[dppm_pkg::AB_ODD_HI:dppm_pkg::AB_ODD_LO]),
    .cpu_ovl_in   (ab_s[dppm_pkg::AB_ODD_OV]),
    .cpu_data_out (cpu_rd_b),
    .pix_clk_in   (PIX_CLK_IN),
    .pix_addr_in  (od_pix),
    .pix_ovl_in   (od_ovl),
    .pix_data_out (pix_b_data)
  );

  // [R12] Pair marker and blank ride with the palette read
  always_ff @(posedge PIX_CLK_IN) begin
    if (pix_rst) begin
      cap_d <= dppm_pkg::RST_BIT;
      lead1 <= dppm_pkg::RST_BIT;
      blk1  <= dppm_pkg::RST_HIGH;
    end else begin
      cap_d <= cap_ev;
      lead1 <= cap_d;
      blk1  <= blk_cap;
    end
  end

  // [R11] Odd byte and pair blank held for the second pixel
  always_ff @(posedge PIX_CLK_IN) begin
    if (pix_rst) begin
      odd_hold <= dppm_pkg::RST_BYTE;
      pair_blk <= dppm_pkg::RST_HIGH;
    end else if (lead1) begin
      odd_hold <= pix_b_data;
      pair_blk <= blk1;
    end
  end

  // [R8] [R19] [R15] [R20] Even first, odd next, blank forces code
  always_ff @(posedge PIX_CLK_IN) begin
    if (pix_rst) begin
      CODE_OUT  <= dppm_pkg::CODE_BLANK;
      BLANK_OUT <= dppm_pkg::RST_HIGH;
    end else if (lead1) begin
      CODE_OUT  <= blk1 ? dppm_pkg::CODE_BLANK : pix_a_data;
      BLANK_OUT <= blk1;
    end else begin
      CODE_OUT  <= pair_blk ? dppm_pkg::CODE_BLANK : odd_hold;
      BLANK_OUT <= pair_blk;
    end
  end

  // ---------------- Checks ----------------
  half_toggle_a: assert property ( // [R9]
    @(posedge PIX_CLK_IN) disable iff (pix_rst)
    (HALF_RATE_CLK_IN == HALF_RATE_CLK_N_OUT) |=> $changed(HALF_RATE_CLK_N_OUT))
    else $error("divider output did not toggle in loopback");

  capture_gate_a: assert property ( // [R5] [R16]
    @(posedge PIX_CLK_IN) disable iff (pix_rst)
    (cap_ev && !cpu_pix) |=> ev_pix == $past(EVEN_PIXEL_IN) && od_ovl == $past(ODD_OVERLAY_SEL_IN))
    else $error("pixel pair not captured on divider fall");

  hold_pixels_a: assert property ( // [R16]
    @(posedge PIX_CLK_IN) disable iff (pix_rst)
    (!cap_ev && !cpu_pix) |=> $stable(ev_pix) && $stable(od_pix) && $stable(blk_cap))
    else $error("pixel registers changed between captures");

  transparent_pipe_a: assert property ( // [R2]
    @(posedge PIX_CLK_IN) disable iff (pix_rst)
    cpu_pix |=> (ev_pix == $past(EVEN_PIXEL_IN)) && (od_pix == $past(ODD_PIXEL_IN)))
    else $error("pipeline not transparent during access");

  blank_pair_a: assert property ( // [R10] [R11] [R12]
    @(posedge PIX_CLK_IN) disable iff (pix_rst)
    (cap_ev && !cpu_pix && BLANK_IN) |-> ##3 BLANK_OUT [*2])
    else $error("captured blank did not cover the pixel pair");

  blank_code_a: assert property ( // [R15]
    @(posedge PIX_CLK_IN) disable iff (pix_rst)
    BLANK_OUT |-> (CODE_OUT == dppm_pkg::CODE_BLANK))
    else $error("code not forced while blanking");

  even_first_a: assert property ( // [R19] [R8]
    @(posedge PIX_CLK_IN) disable iff (pix_rst)
    (lead1 && !blk1) |=> (CODE_OUT == $past(pix_a_data)) ##1 (CODE_OUT == $past(odd_hold)))
    else $error("even then odd order broken");

  addr_first_a: assert property ( // [R17]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (cpu_state == dppm_pkg::CPU_IDLE && wr_act) |=>
      (wr_addr_a == $past(ab_s[dppm_pkg::AB_EVEN_HI:dppm_pkg::AB_EVEN_LO])))
    else $error("write address not taken at access start");
  write_both_a: assert property ( // [R3] [R17]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (cpu_state == dppm_pkg::CPU_WRITE && !wr_act) |=>
      wr_pulse && (wr_data == $past(data_s)) ##1 !wr_pulse)
    else $error("write pulse or data wrong at access end");

  read_select_a: assert property ( // [R4]
    @(posedge CLK_IN) disable iff (SYS_RST_IN)
    (cpu_state == dppm_pkg::CPU_READ_B) [*2] |-> DATA_OE_OUT && (DATA_OUT == $past(cpu_rd_b)))
    else $error("read of palette B not driven");

endmodule : dppm_top

// >>> hdl/dppm_pkg.sv
/*
  Shared constants, state type and index helper for the dual palette pixel mux.
  Assumes every design file refers to these names through the package scope.
*/
package dppm_pkg;

  // Data and memory shape
  localparam int          DATA_W     = 8;
  localparam int          PAL_DEPTH  = 256;
  localparam int          OVL_DEPTH  = 16;
  localparam int          OVL_IDX_W  = 4;
  localparam int          SYNC_W_CPU = 4;
  localparam int          ADDR_BUS_W = 18;

  // Converter codes
  localparam logic [7:0]  CODE_WHITE = 8'hFF;
  localparam logic [7:0]  CODE_BLACK = 8'h00;
  localparam logic [7:0]  CODE_BLANK = 8'h00;

  // Reset values
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic        RST_BIT    = 1'b0;
  localparam logic        RST_HIGH   = 1'b1;

  // Field positions inside the synchronised processor strobe group
  localparam int          STB_CS     = 0;
  localparam int          STB_WR     = 1;
  localparam int          STB_RDA    = 2;
  localparam int          STB_RDB    = 3;

  // Field positions inside the synchronised address and overlay select group
  localparam int          AB_EVEN_LO = 0;
  localparam int          AB_EVEN_HI = 7;
  localparam int          AB_ODD_LO  = 8;
  localparam int          AB_ODD_HI  = 15;
  localparam int          AB_EVEN_OV = 16;
  localparam int          AB_ODD_OV  = 17;

  // Processor access states
  typedef enum logic [3:0] {
    CPU_IDLE   = 4'b0001,
    CPU_WRITE  = 4'b0010,
    CPU_READ_A = 4'b0100,
    CPU_READ_B = 4'b1000
  } dppm_cpu_state_type;

  // Overlay index: upper nibble of the pixel is ignored
  function automatic logic [3:0] dppm_ovl_index(input logic [7:0] pixel);
    dppm_ovl_index = pixel[3:0];
  endfunction : dppm_ovl_index

endpackage : dppm_pkg

// >>> hdl/dppm_sync.sv
/*
  Two flip-flop level synchroniser of configurable width.
  Assumes its input is a level from another clock domain or a pin.
*/
`timescale 1ns/1ps
module dppm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,   // Destination clock
  input  wire logic [W-1:0] d_in,     // Asynchronous level
  output      logic [W-1:0] q_out     // Synchronised level
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    meta  <= d_in;
    q_out <= meta;
  end

endmodule : dppm_sync

// >>> hdl/dppm_palette.sv
/*
  One palette copy: 256 x 8 colour table plus 16 x 8 overlay table.
  Written and read by the processor on the system clock, read by the pixel
  path on the pixel clock. Assumes writes and pixel reads of one cell never
  collide in a way that matters, since the display is blanked meanwhile.
*/
`timescale 1ns/1ps
module dppm_palette (
  input  wire logic       sys_clk_in,   // System clock
  input  wire logic       wr_en_in,     // One-cycle write pulse
  input  wire logic [7:0] wr_addr_in,   // Write pixel address
  input  wire logic       wr_ovl_in,    // Write overlay select
  input  wire logic [7:0] wr_data_in,   // Write byte
  input  wire logic [7:0] cpu_addr_in,  // Processor read address
  input  wire logic       cpu_ovl_in,   // Processor read overlay select
  output      logic [7:0] cpu_data_out, // Processor read byte
  input  wire logic       pix_clk_in,   // Pixel clock
  input  wire logic [7:0] pix_addr_in,  // Pixel address
  input  wire logic       pix_ovl_in,   // Pixel overlay select
  output      logic [7:0] pix_data_out  // Pixel read byte
);

  logic [7:0] colour_mem [dppm_pkg::PAL_DEPTH];
  logic [7:0] overlay_mem [dppm_pkg::OVL_DEPTH];

  // Processor write into colour or overlay table
  always_ff @(posedge sys_clk_in) begin
    if (wr_en_in) begin
      if (wr_ovl_in) begin
        overlay_mem[dppm_pkg::dppm_ovl_index(wr_addr_in)] <= wr_data_in;
      end else begin
        colour_mem[wr_addr_in] <= wr_data_in;
      end
    end
  end

  // Processor read port
  always_ff @(posedge sys_clk_in) begin
    cpu_data_out <= cpu_ovl_in ? overlay_mem[dppm_pkg::dppm_ovl_index(cpu_addr_in)]
                               : colour_mem[cpu_addr_in];
  end

  // Pixel read port
  always_ff @(posedge pix_clk_in) begin
    pix_data_out <= pix_ovl_in ? overlay_mem[dppm_pkg::dppm_ovl_index(pix_addr_in)]
                               : colour_mem[pix_addr_in];
  end

endmodule : dppm_palette

// >>> verification/dppm_far_model.sv
/*
  Far-side model: asynchronous processor strobe bus and frame-buffer pixel pins.
  Assumes the bench calls its tasks one at a time and never overlaps them.
*/
`timescale 1ns/1ps
module dppm_far_model (
  input  wire logic       clk_in,         // System clock
  input  wire logic [7:0] data_in,        // Device data drive value
  input  wire logic       data_oe_in,     // Device data drive enable
  output      logic [7:0] even_pixel_out, // Even pixel or palette address
  output      logic [7:0] odd_pixel_out,  // Odd pixel or palette address
  output      logic       even_ovl_out,   // Even overlay select
  output      logic       odd_ovl_out,    // Odd overlay select
  output      logic       blank_out,      // Composite blank
  output      logic       cs_n_out,       // Chip select, active low
  output      logic       wr_n_out,       // Write strobe, active low
  output      logic       rda_n_out,      // Read palette A, active low
  output      logic       rdb_n_out,      // Read palette B, active low
  output      logic [7:0] bus_out         // Resolved data bus level
);
  logic [7:0] drv;
  logic       drv_en;
  logic [7:0] junk;

  // Idle levels from time zero
  initial begin
    {even_pixel_out, odd_pixel_out, even_ovl_out, odd_ovl_out} = '0;
    {blank_out, cs_n_out, wr_n_out, rda_n_out, rdb_n_out} = 5'h1f;
    drv = 8'h00;
    drv_en = 1'b0;
    junk = 8'h5a;
  end

  // Undriven bus wanders every cycle so stale data never looks valid
  always @(posedge clk_in) begin
    junk <= junk + 8'h3b;
  end

  // Wire level from both possible drivers
  assign bus_out = data_oe_in ? data_in : (drv_en ? drv : junk);

  // One processor access; kind 0 write, 1 read A, 2 read B
  task automatic mpu_cycle(input int kind, input logic cs_low, input logic [7:0] ea,
                           input logic eo, input logic [7:0] oa, input logic oo,
                           input logic [7:0] d, output logic [7:0] rd, output logic oe);
    @(negedge clk_in);
    blank_out = 1'b1;
    {even_pixel_out, even_ovl_out, odd_pixel_out, odd_ovl_out} = {ea, eo, oa, oo};
    // Stale byte first, so only the late value may be stored
    drv = ~d;
    drv_en = (kind == 0);
    cs_n_out = ~cs_low;
    wr_n_out = (kind != 0);
    rda_n_out = (kind != 1);
    rdb_n_out = (kind != 2);
    repeat (4) @(negedge clk_in);
    drv = d;
    repeat (4) @(negedge clk_in);
    rd = bus_out;
    oe = data_oe_in;
    {cs_n_out, wr_n_out, rda_n_out, rdb_n_out} = 4'hf;
    // Address moves after strobe rise; start value must stick
    {even_pixel_out, even_ovl_out, odd_pixel_out, odd_ovl_out} = ~{ea, eo, oa, oo};
    // Data kept after strobe rise, blank kept after access
    repeat (4) @(negedge clk_in);
    drv_en = 1'b0;
    repeat (2) @(negedge clk_in);
  endtask : mpu_cycle

  // Frame buffer presents one pixel pair
  task automatic show_pair(input logic [7:0] e, input logic eo, input logic [7:0] o,
                           input logic oo, input logic bl);
    {even_pixel_out, even_ovl_out, odd_pixel_out, odd_ovl_out, blank_out} = {e, eo, o, oo, bl};
  endtask : show_pair
endmodule : dppm_far_model

// >>> verification/testbench.sv
/*
  Self-checking bench: palette fill, split and refused writes, reads of both
  palettes, then a random pixel stream checked against shadow palettes.
  Assumes the half-rate clock output is looped back to its input here.
*/
`timescale 1ns/1ps
module testbench;
  localparam int LIMIT = 12000;
  typedef struct {int due; logic [7:0] code; logic blank;} dppm_exp_type;

  logic       clk = 1'b0, pix_clk = 1'b0, rst = 1'b1, half_n, cs_n, wr_n, rda_n, rdb_n;
  logic [7:0] even_pix, odd_pix, bus, data_out, code;
  logic       even_ovl, odd_ovl, blank_in, oe, blank_o, half_prev = 1'b0, stream_on = 1'b0;
  logic [7:0] col_a [256], col_b [256], ov_a [16], ov_b [16], e_p, o_p, a, d;
  logic       e_o, o_o, bl;
  logic [31:0] r;
  integer     seed = 32'h5cc6_d227;
  int         errors = 0, compares = 0, cyc = 0, ncnt = 0, pairs = 0, i;
  dppm_exp_type expq [$];

  // System clock 100 ns, pixel clock 80 ns with an offset phase
  always begin
    #50 clk = ~clk;
  end
  initial begin
    #13;
    forever #40 pix_clk = ~pix_clk;
  end

  dppm_top dut_u (.CLK_IN(clk), .SYS_RST_IN(rst), .PIX_CLK_IN(pix_clk),
    .EVEN_PIXEL_IN(even_pix), .ODD_PIXEL_IN(odd_pix), .EVEN_OVERLAY_SEL_IN(even_ovl),
    .ODD_OVERLAY_SEL_IN(odd_ovl), .BLANK_IN(blank_in), .HALF_RATE_CLK_IN(half_n),
    .HALF_RATE_CLK_N_OUT(half_n), .CHIP_SEL_N_IN(cs_n), .WRITE_STROBE_N_IN(wr_n),
    .READ_STROBE_A_N_IN(rda_n), .READ_STROBE_B_N_IN(rdb_n), .DATA_IN(bus),
    .DATA_OUT(data_out), .DATA_OE_OUT(oe), .CODE_OUT(code), .BLANK_OUT(blank_o));

  dppm_far_model partner_u (.clk_in(clk), .data_in(data_out), .data_oe_in(oe),
    .even_pixel_out(even_pix), .odd_pixel_out(odd_pix), .even_ovl_out(even_ovl),
    .odd_ovl_out(odd_ovl), .blank_out(blank_in), .cs_n_out(cs_n), .wr_n_out(wr_n),
    .rda_n_out(rda_n), .rdb_n_out(rdb_n), .bus_out(bus));

  // Expected palette byte from the shadow tables
  function automatic logic [7:0] pal(input logic b, input logic [7:0] p, input logic o);
    if (o) pal = b ? ov_b[p[3:0]] : ov_a[p[3:0]];
    else pal = b ? col_b[p] : col_a[p];
  endfunction : pal

  // Expected converter code, blank overriding the palette
  function automatic logic [7:0] exp_code(input logic b, input logic [7:0] p,
                                          input logic o, input logic k);
    exp_code = k ? dppm_pkg::CODE_BLANK : pal(b, p, o);
  endfunction : exp_code

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] expv);
    compares = compares + 1;
    if (seen !== expv) begin
      errors = errors + 1;
      $display("unexpected %s expected %h seen %h", what, expv, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : stop_test

  // Processor write plus shadow update
  task automatic wr(input logic [7:0] ea, input logic eo, input logic [7:0] oa,
                    input logic oo, input logic [7:0] dv, input logic cs_low);
    logic [7:0] v;
    logic       e;
    partner_u.mpu_cycle(0, cs_low, ea, eo, oa, oo, dv, v, e);
    check("write drive enable", {7'h00, e}, 8'h00);
    if (cs_low) begin
      if (eo) ov_a[ea[3:0]] = dv;
      else col_a[ea] = dv;
      if (oo) ov_b[oa[3:0]] = dv;
      else col_b[oa] = dv;
    end
  endtask : wr

  // Processor read of one palette and its side effects
  task automatic rd_chk(input logic b, input logic [7:0] ad, input logic o, input logic cs_low);
    logic [7:0] v;
    logic       e;
    partner_u.mpu_cycle(b ? 2 : 1, cs_low, ad, o, ad, o, 8'h00, v, e);
    check("read drive enable", {7'h00, e}, {7'h00, cs_low});
    if (cs_low) check("read data", v, pal(b, ad, o));
    check("release", {7'h00, oe}, 8'h00);
    check("blank in access", {7'h00, blank_o}, 8'h01);
    check("code in access", code, dppm_pkg::CODE_BLANK);
  endtask : rd_chk

  // Hang guard
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == LIMIT) begin
      errors = errors + 1;
      $display("timeout");
      stop_test;
    end
  end

  // Pixel side: present a pair before each capture edge, check the codes
  always @(negedge pix_clk) begin
    ncnt = ncnt + 1;
    if (expq.size() > 0) begin
      if (expq[0].due == ncnt) begin
        check("pixel code", code, expq[0].code);
        check("pixel blank", {7'h00, blank_o}, {7'h00, expq[0].blank});
        void'(expq.pop_front());
      end
    end
    if (stream_on) check("half rate", {7'h00, half_n}, {7'h00, ~half_prev});
    half_prev = half_n;
    if (stream_on && half_n === 1'b1) begin
      r = $random(seed);
      {e_p, o_p, e_o, o_o, bl} = {r[7:0], r[15:8], r[16], r[17], r[19:18] == 2'b00};
      if (pairs < 2) {e_p, o_p, e_o, o_o, bl} = {8'h00, 8'h01, 2'b00, pairs[0]};
      partner_u.show_pair(e_p, e_o, o_p, o_o, bl);
      expq.push_back('{ncnt + 3, exp_code(1'b0, e_p, e_o, bl), bl});
      expq.push_back('{ncnt + 4, exp_code(1'b1, o_p, o_o, bl), bl});
      pairs = pairs + 1;
    end
  end

  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (i = 0; i < 272; i++) begin
      r = $random(seed);
      d = (i == 0) ? dppm_pkg::CODE_WHITE : (i == 1) ? dppm_pkg::CODE_BLACK : r[7:0];
      a = (i < 256) ? i[7:0] : {r[11:8], i[3:0]};
      wr(a, i >= 256, a, i >= 256, d, 1'b1);
    end
    $display("test fill done");
    for (i = 0; i < 25; i++) begin
      r = $random(seed);
      wr(r[7:0], r[8], r[15:8], r[9], r[23:16], i != 0);
    end
    $display("test split writes done");
    for (i = 0; i < 49; i++) begin
      r = $random(seed);
      rd_chk(r[8], r[7:0], r[9], i != 0);
    end
    $display("test reads done");
    repeat (8) @(negedge clk);
    stream_on = 1'b1;
    while (pairs < 300) @(negedge clk);
    stream_on = 1'b0;
    repeat (10) @(negedge clk);
    check("pending pixels", {7'h00, expq.size() != 0}, 8'h00);
    $display("test stream done");
    stop_test;
  end
endmodule : testbench
